// ### design/asr_top.v
// Notes on behaviour
// - Sample SCK at reset end; low selects external
// - Select low: SDO shows pending flag during conversion
// - Pending flag falling loads result into shifter
// - SDO changes on SCK falling; host samples rising
// - External mode: 19th falling edge restarts conversion
// - SCK high at select fall selects internal
// - Weak pull-up active at select falling edge only while SCK reads high
// - Pull-up off whenever SCK reads low outside power-on reset
// - Internal: SDO off when deselected; select drives SCK low
// - Early deselect during status test returns to sleep
// - Status test delay then SCK rises, output starts
// - Internal single: after 19th rise restart, SCK high
// - Deselect mid-readout aborts and restarts conversion
// - Deselect with SCK low: released low, external next
// - Pull-up through reset; internal unless SCK low
// - Continuous: SCK, SDO high converting, low at completion
// - Continuous: 19 rises, then SDO high, SCK high
// - Internal modes drive generated clock onto SCK
// - External single cycle: SCK low at select fall
`timescale 1ns/100ps
`include "asr_defs.vh"
module asr_top #(
   parameter TEST_CYC = `ASR_EOC_TEST_CYC,
   parameter HALF_CYC = `ASR_SCK_HALF_CYC
) (
   input  wire                     ref_clk,
   input  wire                     nrst,
   input  wire                     cs_n_pin,
   input  wire                     sck_pin_in,
   output reg                      sck_pin_out,
   output reg                      sck_pin_oe,
   output reg                      sck_pullup_en,
   output reg                      sdo_out,
   output reg                      sdo_oe,
   input  wire                     por_active,
   input  wire                     oscillator_source_pin,
   input  wire                     osc_is_external,
   input  wire                     conv_done,
   input  wire [`ASR_RES_BITS-1:0] conv_result,
   output reg                      conv_start,
   output reg                      core_awake,
   output reg                      ext_sck_mode
);
   localparam integer          TEST_M1_I = TEST_CYC - 1;
   localparam integer          EXT_E_I   = `ASR_EOC_EXT_EDGES;
   localparam [`ASR_DLY_W-1:0] TEST_M1   = TEST_M1_I[`ASR_DLY_W-1:0];
   localparam [`ASR_DLY_W-1:0] EXT_EDGES = EXT_E_I[`ASR_DLY_W-1:0];
   localparam                  SR_TOP    = `ASR_RES_BITS;

   wire [`ASR_SYN_W-1:0] syn_lvl;
   wire [`ASR_SYN_W-1:0] syn_rise;
   wire [`ASR_SYN_W-1:0] syn_fall;
   wire                  gen_rise;
   wire                  gen_fall;

   reg  [2:0]                state;
   reg                       cont;
   reg  [`ASR_RES_BITS:0]    sr;
   reg  [`ASR_CNT_W-1:0]     rcnt;
   reg  [`ASR_DLY_W-1:0]     dcnt;
   wire                      cs_lvl   = syn_lvl[`ASR_SYN_CS];
   wire                      cs_rise  = syn_rise[`ASR_SYN_CS];
   wire                      cs_fall  = syn_fall[`ASR_SYN_CS];
   wire                      sck_lvl  = syn_lvl[`ASR_SYN_SCK];
   wire                      sck_rise = syn_rise[`ASR_SYN_SCK];
   wire                      sck_fall = syn_fall[`ASR_SYN_SCK];
   wire                      por_lvl  = syn_lvl[`ASR_SYN_POR];
   wire                      por_fall = syn_fall[`ASR_SYN_POR];
   wire                      osc_rise = syn_rise[`ASR_SYN_OSC];
   wire                      test_done;

   asr_sync #(
      .WIDTH (`ASR_SYN_W),
      .RST   (`ASR_SYN_RST)
   ) u_sync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .pin     ({oscillator_source_pin, por_active, sck_pin_in, cs_n_pin}),
      .lvl     (syn_lvl),
      .rise    (syn_rise),
      .fall    (syn_fall)
   );

   asr_clkgen #(
      .HALF (HALF_CYC),
      .W    (`ASR_DLY_W)
   ) u_clkgen (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .run     (state == `ASR_ST_OUT),
      .rise_p  (gen_rise),
      .fall_p  (gen_fall)
   );

   // Internal oscillator counts reference cycles; an external one counts its own edges
   assign test_done = osc_is_external ? (dcnt == EXT_EDGES) : (dcnt == TEST_M1);

   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state         <= `ASR_ST_POR;
         cont          <= 1'b0;
         sr            <= {(`ASR_RES_BITS+1){1'b1}};
         rcnt          <= `ASR_CNT_ZERO;
         dcnt          <= `ASR_DLY_ZERO;
         sck_pin_out   <= 1'b1;
         sck_pin_oe    <= 1'b0;
         sck_pullup_en <= 1'b1;
         sdo_out       <= 1'b1;
         sdo_oe        <= 1'b0;
         conv_start    <= 1'b0;
         core_awake    <= 1'b0;
         ext_sck_mode  <= 1'b0;
      end
      else
      begin
         conv_start    <= 1'b0;
         // Pull-up while the pin reads high or during power-on reset, so a released low pin stays low
         sck_pullup_en <= por_lvl | sck_lvl;
         // Deselecting releases SCK at whatever level it had; no restore
         // Held off while the mode is latched, so a pin the host holds low is never fought
         sck_pin_oe    <= !ext_sck_mode && !cs_lvl && !por_lvl && !cs_fall && !por_fall;
         sdo_oe        <= !cs_lvl && !por_lvl;
         sdo_out       <= (state == `ASR_ST_CONV) ? 1'b1 : sr[SR_TOP];
         core_awake    <= (state == `ASR_ST_TEST) || (state == `ASR_ST_OUT);
         if (cs_fall && (state != `ASR_ST_POR))
         begin
            ext_sck_mode <= !sck_lvl;
            cont         <= 1'b0;
         end
         case (state)
            `ASR_ST_POR:
            begin
               if (por_fall)
               begin
                  ext_sck_mode <= !sck_lvl;
                  cont         <= sck_lvl;
                  sck_pin_out  <= 1'b1;
                  conv_start   <= 1'b1;
                  state        <= `ASR_ST_CONV;
               end
            end
            `ASR_ST_CONV:
            begin
               if (cs_fall && sck_lvl && !cont)
               begin
                  sck_pin_out <= 1'b0;
               end
               if (conv_done)
               begin
                  sr   <= {1'b0, conv_result};
                  rcnt <= `ASR_CNT_ZERO;
                  dcnt <= `ASR_DLY_ZERO;
                  if (!ext_sck_mode && !cs_lvl)
                  begin
                     sck_pin_out <= 1'b0;
                     state       <= `ASR_ST_TEST;
                  end
                  else
                  begin
                     state <= `ASR_ST_SLEEP;
                  end
               end
            end
            `ASR_ST_SLEEP:
            begin
               if (cs_fall && sck_lvl)
               begin
                  sck_pin_out <= 1'b0;
                  dcnt        <= `ASR_DLY_ZERO;
                  rcnt        <= `ASR_CNT_ZERO;
                  state       <= `ASR_ST_TEST;
               end
               else if (ext_sck_mode && cs_rise && (rcnt != `ASR_CNT_ZERO))
               begin
                  conv_start <= 1'b1;
                  state      <= `ASR_ST_CONV;
               end
               else if (ext_sck_mode && !cs_lvl)
               begin
                  if (sck_rise)
                  begin
                     rcnt <= rcnt + `ASR_CNT_ONE;
                  end
                  else if (sck_fall && (rcnt != `ASR_CNT_ZERO))
                  begin
                     sr <= {sr[SR_TOP-1:0], 1'b1};
                     if (rcnt == `ASR_FRAME_BITS)
                     begin
                        conv_start <= 1'b1;
                        state      <= `ASR_ST_CONV;
                     end
                  end
               end
            end
            `ASR_ST_TEST:
            begin
               if (cs_rise && !cont)
               begin
                  state <= `ASR_ST_SLEEP;
               end
               else if (test_done)
               begin
                  sck_pin_out <= 1'b1;
                  rcnt        <= `ASR_CNT_ONE;
                  state       <= `ASR_ST_OUT;
               end
               else if (!osc_is_external || osc_rise)
               begin
                  dcnt <= dcnt + `ASR_DLY_ONE;
               end
            end
            `ASR_ST_OUT:
            begin
               if (cs_rise && !cont)
               begin
                  conv_start <= 1'b1;
                  state      <= `ASR_ST_CONV;
               end
               else if (gen_fall)
               begin
                  sck_pin_out <= 1'b0;
                  sr          <= {sr[SR_TOP-1:0], 1'b1};
               end
               else if (gen_rise)
               begin
                  sck_pin_out <= 1'b1;
                  rcnt        <= rcnt + `ASR_CNT_ONE;
                  if ((rcnt + `ASR_CNT_ONE) == `ASR_FRAME_BITS)
                  begin
                     // SCK stays high through the next conversion
                     conv_start <= 1'b1;
                     state      <= `ASR_ST_CONV;
                  end
               end
            end
            default:
            begin
               state <= `ASR_ST_POR;
            end
         endcase
      end
   end
endmodule // asr_top

// ### design/asr_defs.vh
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH

// Frame layout: one status bit followed by the result bits
`define ASR_FRAME_BITS      5'h13
`define ASR_RES_BITS        18
`define ASR_CNT_W           5
`define ASR_CNT_ZERO        5'h00
`define ASR_CNT_ONE         5'h01

// Reference clock period in ns
`define ASR_CLK_NS          25

// Status test delay, internal oscillator (least time, rounded up)
`define ASR_EOC_TEST_NS     23000
`define ASR_EOC_TEST_CYC    ((`ASR_EOC_TEST_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)

// Status test delay, external oscillator: 3.6 periods, kept in tenths, rounded up
`define ASR_EOC_EXT_X10     36
`define ASR_EOC_EXT_EDGES   ((`ASR_EOC_EXT_X10 + 9) / 10)

// Internal serial clock half period (longest time, rounded down)
`define ASR_SCK_HALF_NS     28680
`define ASR_SCK_HALF_CYC    (`ASR_SCK_HALF_NS / `ASR_CLK_NS)

`define ASR_DLY_W           11
`define ASR_DLY_ZERO        11'h000
`define ASR_DLY_ONE         11'h001

// Synchroniser bit positions and reset levels
`define ASR_SYN_W           4
`define ASR_SYN_CS          0
`define ASR_SYN_SCK         1
`define ASR_SYN_POR         2
`define ASR_SYN_OSC         3
`define ASR_SYN_RST         4'h7

// States
`define ASR_ST_POR          3'h0
`define ASR_ST_CONV         3'h1
`define ASR_ST_SLEEP        3'h2
`define ASR_ST_TEST         3'h3
`define ASR_ST_OUT          3'h4

`endif

// ### design/asr_sync.v
`timescale 1ns/100ps
// Three-stage pin synchroniser; a level is accepted once stages two and three agree
module asr_sync #(
   parameter            WIDTH = 4,
   parameter [WIDTH-1:0] RST  = {WIDTH{1'b0}}
) (
   input  wire             ref_clk,
   input  wire             nrst,
   input  wire [WIDTH-1:0] pin,
   output reg  [WIDTH-1:0] lvl,
   output reg  [WIDTH-1:0] rise,
   output reg  [WIDTH-1:0] fall
);
   reg [WIDTH-1:0] ff1;
   reg [WIDTH-1:0] ff2;
   reg [WIDTH-1:0] ff3;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         always @(posedge ref_clk or negedge nrst)
         begin
            if (!nrst)
            begin
               ff1[i]  <= RST[i];
               ff2[i]  <= RST[i];
               ff3[i]  <= RST[i];
               lvl[i]  <= RST[i];
               rise[i] <= 1'b0;
               fall[i] <= 1'b0;
            end
            else
            begin
               ff1[i]  <= pin[i];
               ff2[i]  <= ff1[i];
               ff3[i]  <= ff2[i];
               rise[i] <= (ff2[i] == ff3[i]) && ff3[i] && !lvl[i];
               fall[i] <= (ff2[i] == ff3[i]) && !ff3[i] && lvl[i];
               if (ff2[i] == ff3[i])
               begin
                  lvl[i] <= ff3[i];
               end
            end
         end
      end
   endgenerate
endmodule // asr_sync

// ### design/asr_clkgen.v
`timescale 1ns/100ps
// Internal shift clock: starts high when run rises, toggles every HALF cycles
module asr_clkgen #(
   parameter HALF = 1147,
   parameter W    = 11
) (
   input  wire ref_clk,
   input  wire nrst,
   input  wire run,
   output reg  rise_p,
   output reg  fall_p
);
   localparam integer HALF_M1_I = HALF - 1;
   localparam [W-1:0] HALF_M1   = HALF_M1_I[W-1:0];
   localparam [W-1:0] ZERO    = {W{1'b0}};
   localparam [W-1:0] ONE     = {{(W-1){1'b0}}, 1'b1};

   reg [W-1:0] cnt;
   reg         phase;

   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt    <= ZERO;
         phase  <= 1'b1;
         rise_p <= 1'b0;
         fall_p <= 1'b0;
      end
      else
      begin
         rise_p <= 1'b0;
         fall_p <= 1'b0;
         if (!run)
         begin
            cnt   <= ZERO;
            phase <= 1'b1;
         end
         else if (cnt == HALF_M1)
         begin
            cnt    <= ZERO;
            phase  <= !phase;
            rise_p <= !phase;
            fall_p <= phase;
         end
         else
         begin
            cnt <= cnt + ONE;
         end
      end
   end
endmodule // asr_clkgen

// ### tb/asr_host.sv
`timescale 1ns/100ps
module asr_host (
   input  wire ref_clk,
   input  wire sck_pin_out,
   input  wire sck_pin_oe,
   input  wire sck_pullup_en,
   input  wire sdo_out,
   input  wire sdo_oe,
   output reg  cs_n_pin,
   output reg  sck_pin_in
);
   reg drv;
   reg val;
   reg ext_pu;
   initial
   begin
      cs_n_pin = 1'b0;
      drv = 1'b0;
      val = 1'b0;
      ext_pu = 1'b0;
   end
   // Released SCK keeps its level unless a pull-up acts, so a low stays low
   always @*
      if (sck_pin_oe)
         sck_pin_in = sck_pin_out;
      else if (drv)
         sck_pin_in = val;
      else if (sck_pullup_en || ext_pu)
         sck_pin_in = 1'b1;
   // Host clock, 200 ns period; a bit is taken at the end of its high phase
   task ext_frame(output [18:0] g);
      begin
         g = 19'h00000;
         repeat (19)
         begin
            val <= 1'b1;
            repeat (4) @(posedge ref_clk);
            g = {g[17:0], sdo_out};
            val <= 1'b0;
            repeat (4) @(posedge ref_clk);
         end
      end
   endtask
   task int_frame(input integer n, output [18:0] g);
      begin
         g = 19'h00000;
         repeat (n)
         begin
            @(posedge sck_pin_out);
            g = {g[17:0], sdo_out};
         end
      end
   endtask
endmodule // asr_host

// ### tb/asr_top_chk.sv
`timescale 1ns/100ps
module asr_top_chk #(
   parameter TEST_CYC = 920,
   parameter HALF_CYC = 1147
) (
   input wire ref_clk,
   input wire nrst,
   input wire cs_n_pin,
   input wire sck_pin_in,
   input wire sck_pin_out,
   input wire sck_pin_oe,
   input wire sck_pullup_en,
   input wire sdo_out,
   input wire sdo_oe,
   input wire por_active,
   input wire conv_done,
   input wire conv_start,
   input wire ext_sck_mode,
   input wire osc_is_external
);
   reg [10:0] lo_cnt;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Low time of driven SCK: either one generated half or the status test
   always @(posedge ref_clk or negedge nrst)
      if (!nrst)
         lo_cnt <= 11'h000;
      else if (sck_pin_oe && !sck_pin_out)
         lo_cnt <= lo_cnt + 11'h001;
      else
         lo_cnt <= 11'h000;
   property p_pullup_off;
      (!sck_pin_in && !por_active) [*6] |-> !sck_pullup_en;
   endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("pull-up on, SCK low");
   property p_sdo_hiz;
      cs_n_pin [*7] |-> !sdo_oe;
   endproperty
   a_sdo_hiz: assert property (p_sdo_hiz) else $error("SDO driven while deselected");
   property p_conv_sdo;
      conv_start |-> ##[1:2] sdo_out;
   endproperty
   a_conv_sdo: assert property (p_conv_sdo) else $error("SDO low in conversion");
   property p_sck_high;
      conv_start && !ext_sck_mode |-> ##[1:2] (!sck_pin_oe || sck_pin_out);
   endproperty
   a_sck_high: assert property (p_sck_high) else $error("SCK not high in conversion");
   property p_lo_time;
      $rose(sck_pin_out) && sck_pin_oe && !osc_is_external |->
         lo_cnt == HALF_CYC || (lo_cnt >= TEST_CYC - 1 && lo_cnt <= TEST_CYC + 3);
   endproperty
   a_lo_time: assert property (p_lo_time) else $error("SCK low time wrong");
   property p_sel_ext;
      (!sck_pin_in && $fell(cs_n_pin)) ##1 !sck_pin_in [*4] |-> ##[0:3] ext_sck_mode;
   endproperty
   a_sel_ext: assert property (p_sel_ext) else $error("external mode not chosen");
   property p_sel_int;
      (sck_pin_in && $fell(cs_n_pin)) ##1 sck_pin_in [*3] |-> ##[1:4] (!ext_sck_mode && sck_pin_oe);
   endproperty
   a_sel_int: assert property (p_sel_int) else $error("internal mode not chosen");
   property p_cont_done;
      conv_done && !cs_n_pin && sck_pin_oe && sck_pin_out && !ext_sck_mode |-> ##[1:3] !sck_pin_out;
   endproperty
   a_cont_done: assert property (p_cont_done) else $error("SCK high after completion");
endmodule // asr_top_chk
bind asr_top asr_top_chk #(.TEST_CYC(TEST_CYC), .HALF_CYC(HALF_CYC)) u_chk (.ref_clk, .nrst, .cs_n_pin,
   .sck_pin_in, .sck_pin_out, .sck_pin_oe, .sck_pullup_en, .sdo_out, .sdo_oe, .por_active, .conv_done,
   .conv_start, .ext_sck_mode, .osc_is_external);

// ### tb/asr_top_tb.sv
`timescale 1ns/100ps
module asr_top_tb;
   reg        ref_clk;
   reg        nrst;
   reg        por_active;
   reg        oscillator_source_pin;
   reg        osc_is_external;
   reg        conv_done;
   reg [17:0] conv_result;
   reg [18:0] got;
   reg [1:0]  osc_div;
   wire       cs_n_pin, sck_pin_in, sck_pin_out, sck_pin_oe, sck_pullup_en;
   wire       sdo_out, sdo_oe, conv_start, core_awake, ext_sck_mode;
   integer    error_cnt, n_tests, n_start, t0;
   asr_top #(.TEST_CYC(8), .HALF_CYC(8)) DUT (.ref_clk, .nrst, .cs_n_pin, .sck_pin_in, .sck_pin_out,
      .sck_pin_oe, .sck_pullup_en, .sdo_out, .sdo_oe, .por_active, .oscillator_source_pin,
      .osc_is_external, .conv_done, .conv_result, .conv_start, .core_awake, .ext_sck_mode);
   asr_host HOST (.ref_clk, .sck_pin_out, .sck_pin_oe, .sck_pullup_en, .sdo_out, .sdo_oe, .cs_n_pin,
      .sck_pin_in);
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (conv_start === 1'b1)
         n_start <= n_start + 1;
   // Free-running external oscillator, 200 ns period
   always @(posedge ref_clk)
   begin
      osc_div <= osc_div + 2'b01;
      if (osc_div == 2'b11)
         oscillator_source_pin <= ~oscillator_source_pin;
   end
   task chk(input [18:0] g, input [18:0] e);
      begin
         n_tests = n_tests + 1;
         if (g !== e)
         begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge ref_clk);
   endtask
   task wrap_up;
      begin
         if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task done(input [17:0] r);
      begin
         conv_done <= 1'b1;
         conv_result <= r;
         cyc(1);
         conv_done <= 1'b0;
      end
   endtask
   task por(input low);
      begin
         nrst <= 1'b0;
         por_active <= 1'b1;
         HOST.drv <= low;
         HOST.val <= 1'b0;
         cyc(2);
         nrst <= 1'b1;
         cyc(4);
         por_active <= 1'b0;
         t0 = n_start;
         cyc(12);
         chk(n_start - t0, 1);
         chk(ext_sck_mode, low);
      end
   endtask
   task t_ext;
      begin
         por(1'b1);
         chk({sdo_oe, sdo_out}, 2'b11);
         done(18'h2A5C3);
         cyc(4);
         chk({sdo_oe, sdo_out}, 2'b10);
         t0 = n_start;
         HOST.ext_frame(got);
         cyc(4);
         chk(got, {1'b0, 18'h2A5C3});
         chk(n_start - t0, 1);
         chk(sdo_out, 1);
      end
   endtask
   task t_int;
      begin
         HOST.val <= 1'b1;
         cyc(6);
         HOST.drv <= 1'b0;
         HOST.cs_n_pin <= 1'b1;
         done(18'h15A3C);
         cyc(8);
         chk({sdo_oe, sck_pin_in, sck_pullup_en}, 3'b011);
         HOST.cs_n_pin <= 1'b0;
         cyc(8);
         chk({ext_sck_mode, sck_pin_oe, sck_pin_out, sdo_out}, 4'b0100);
         t0 = n_start;
         HOST.int_frame(19, got);
         cyc(4);
         chk(got, {1'b0, 18'h15A3C});
         chk(n_start - t0, 1);
         chk({sck_pin_oe, sck_pin_out, sdo_out}, 3'b111);
      end
   endtask
   task t_abort;
      begin
         HOST.cs_n_pin <= 1'b1;
         HOST.ext_pu <= 1'b1;
         cyc(6);
         done(18'h3C0F1);
         cyc(8);
         t0 = n_start;
         HOST.cs_n_pin <= 1'b0;
         cyc(5);
         HOST.cs_n_pin <= 1'b1;
         cyc(12);
         chk({core_awake, sck_pin_in, ext_sck_mode}, 3'b010);
         chk(n_start - t0, 0);
         HOST.ext_pu <= 1'b0;
         HOST.cs_n_pin <= 1'b0;
         HOST.int_frame(5, got);
         chk(got, 19'h0000F);
         @(negedge sck_pin_out);
         HOST.cs_n_pin <= 1'b1;
         cyc(10);
         chk(n_start - t0, 1);
         chk({sck_pin_oe, sck_pin_in, sck_pullup_en}, 3'b000);
         HOST.cs_n_pin <= 1'b0;
         cyc(8);
         chk(ext_sck_mode, 1);
      end
   endtask
   task t_cont;
      begin
         HOST.cs_n_pin <= 1'b0;
         por(1'b0);
         chk({sck_pin_oe, sck_pin_out, sdo_out}, 3'b111);
         t0 = n_start;
         done(18'h0F0F0);
         cyc(3);
         chk({sck_pin_oe, sck_pin_out, sdo_out}, 3'b100);
         HOST.int_frame(19, got);
         cyc(4);
         chk(got, {1'b0, 18'h0F0F0});
         chk(n_start - t0, 1);
         chk({sck_pin_oe, sck_pin_out}, 2'b11);
         // 4 periods of 200 ns (3.6 rounded up): far longer than the shortened internal delay
         osc_is_external <= 1'b1;
         t0 = $time;
         done(18'h30C0F);
         @(posedge sck_pin_out);
         chk(($time - t0) >= 600 && ($time - t0) <= 1100, 1);
         HOST.int_frame(18, got);
         chk(got, {1'b0, 18'h30C0F});
      end
   endtask
   initial
   begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      por_active = 1'b1;
      oscillator_source_pin = 1'b0;
      osc_div = 2'b00;
      osc_is_external = 1'b0;
      conv_done = 1'b0;
      conv_result = 18'h00000;
      error_cnt = 0;
      n_tests = 0;
      n_start = 0;
      t_ext;
      t_int;
      t_abort;
      t_cont;
      wrap_up;
   end
   // Whole run is near 1300 cycles; a hang on SCK edges ends here
   initial
   begin
      #200000;
      error_cnt = error_cnt + 1;
      wrap_up;
   end
endmodule // asr_top_tb
